// File: lag_correlator_delay_multiplier_bench.sv
// self-checking bench: register access, continuum and spectral product counts
`timescale 1ns/1ps
`default_nettype none
module lag_correlator_delay_multiplier_bench;
  import ldm_pkg::*;
  localparam int INTEG = 200;
  localparam int DMAX  = 100;
  logic        i_clk_sys, i_rst, i_psel, i_penable, i_pwrite, load, err;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, o_handover;
  logic [15:0] xs, ys, xv, yv;
  logic [1:0]  wv;
  int          n_fail, comparisons, seed;
  logic [11:0] ro[4]  = '{OFS_CTRL, OFS_DELAY, OFS_STATUS, OFS_EPOCH};
  logic [11:0] bad[4] = '{12'h014, 12'h802, OFS_EPOCH, OFS_MULTS};
  ldm_correlator #(.DELAY_MAX_P(DMAX), .INTEG_CYCLES_P(INTEG)) DUT (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_x_samples(xs), .i_y_samples(ys),
    .i_x_walsh(wv[0]), .i_y_walsh(wv[1]), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_handover(o_handover));
  ldm_sampler_model u_samp (.i_clk_sys(i_clk_sys), .i_load(load), .i_x_code(xv),
    .i_y_code(yv), .o_x_samples(xs), .o_y_samples(ys));
  // ============================================================
  // checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ============================================================
  // apb master: one idle edge first so release and setup never share a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge i_clk_sys);
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= a;
    i_pwdata <= wd;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic wait_handover(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge i_clk_sys);
        k++;
      end while (o_handover !== 1'b1 && k < 1000);
      if (k >= 1000) begin
        n_fail++;
        summarize();
      end
    end
  endtask
  // ============================================================
  // reference model of one integration period
  function automatic logic [1:0] comp(input logic [15:0] s, input logic w, input int ch, input int c);
    logic [1:0] r;
    r = s[4*ch+2*c +: 2];
    r[0] = r[0] ^ w;
    return r;
  endfunction
  function automatic int prod(input logic [1:0] a, input logic [1:0] b);
    if (a[1] && b[1]) return (a[0] == b[0]) ? 2 : 0;
    return 1;
  endfunction
  // x/y selector: bit1 picks left, bit0 picks cosine
  function automatic int expect_hold(input int i, input logic en, input logic pol, input logic sp);
    int ysel[16] = '{0, 1, 2, 3, 2, 3, 0, 1, 1, 0, 3, 2, 3, 2, 1, 0};
    int p;
    logic [1:0] a;
    p = int'(pol);
    // spectral at full rate on band b: lags 0..15 and negative lag 0 all see the same constant pair
    if (en && sp) return (i < 16 || i == 34) ?
      INTEG * prod(comp(xv, wv[0], 1, 0), comp(yv, wv[1], 1, 0)) : 0;
    if (!en || i > 31) return 0;
    if (i < 16) return INTEG * prod(comp(xv, wv[0], ((i % 4) / 2 ? 0 : 2) + p, i % 2),
      comp(yv, wv[1], (ysel[i] / 2 ? 0 : 2) + p, ysel[i] % 2));
    a = (i < 24) ? comp(xv, wv[0], (i - 16) / 2, i % 2) : comp(yv, wv[1], (i - 24) / 2, i % 2);
    return INTEG * prod(a, a);
  endfunction
  // ============================================================
  // stimulus
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    seed = 89914;
    n_fail = 0;
    comparisons = 0;
    {i_psel, i_penable, i_pwrite, load} = 4'h0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0;
    {xv, yv, wv} = '0;
    i_rst = 1'b1;
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      apb(1'b0, ro[n], 32'h0);
      check("reset value", rd & ((n == 2) ? 32'h1 : 32'hFFFFFFFF), 32'h0);
    end
    for (int n = 0; n < 4; n++) begin
      apb(1'b1, bad[n], 32'hFFFFFFFF);
      check("refused write", {31'h0, err}, 32'h1);
    end
    apb(1'b0, 12'h014, 32'h0);
    check("unmapped read", {rd[30:0], err}, 32'h1);
    apb(1'b1, OFS_DELAY, 32'h7FFF);
    apb(1'b0, OFS_DELAY, 32'h0);
    check("delay clamp", rd, 32'(DMAX));
    apb(1'b1, OFS_DELAY, 32'h25);
    apb(1'b0, OFS_DELAY, 32'h0);
    check("delay", rd, 32'h25);
    for (int s = 0; s < 5; s++) begin
      xv <= 16'($random(seed)) | 16'h2222;
      yv <= 16'($random(seed)) | 16'h2222;
      wv <= 2'($random(seed));
      load <= 1'b1;
      @(posedge i_clk_sys);
      load <= 1'b0;
      // the last pass runs spectral, single band on channel b, no decimation
      apb(1'b1, OFS_CTRL, (s == 3) ? 32'h0 : (s == 4) ? (32'h3 | (32'h1 << CTRL_BAND0_LSB)) :
        (32'h1 | (32'(s % 2) << CTRL_POL_BIT)));
      // the first two periods may still hold old samples in the pipeline
      wait_handover(3);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("ready", rd & 32'h1, 32'h1);
      apb(1'b1, OFS_STATUS, 32'h1);
      apb(1'b0, OFS_STATUS, 32'h0);
      check("ready clear", rd & 32'h1, 32'h0);
      apb(1'b0, OFS_MULTS, 32'h0);
      check("mults", rd, (s == 3) ? 32'h0 : 32'(INTEG));
      // entry 34 reads hold 256, the first negative-lag channel
      for (int i = 0; i < 35; i++) begin
        apb(1'b0, 12'h800 + 12'(4 * ((i == 34) ? 256 : i)), 32'h0);
        check("hold", rd, 32'(expect_hold(i, s != 3, 1'(s % 2), s == 4)));
      end
    end
    summarize();
  end
endmodule
bind ldm_correlator ldm_correlator_properties #(.INTEG_CYCLES_P(INTEG_CYCLES_P)) u_props (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_handover(o_handover));
`default_nettype wire

// File: ldm_correlator.sv
// delay, three-level multiply and integrate correlator for one antenna pair
`timescale 1ns/1ps
`default_nettype none

// How it works
// - sign bit of every sample is flipped by the antenna walsh function first
// - each 100 mhz x stream is demultiplexed into sixteen 6.25 mhz lanes; y streams only pass a fixed latency
// - lane storage is built from 512 and 256 bit segments
// - delay spans 164 us and lanes are re-serialised at 100 mhz
// - host loads delay over the controller port and reads monitor data there
// - multipliers run every clock, nonzero only for two high-magnitude samples
// - products -1, 0, +1 count as 0, 1, 2 in up counters
// - counters are handed over every 52 ms; longer sums are the controller's
// - sixteen cross multipliers per pair form sine-sine, sine-cosine, cosine-sine and cosine-cosine products
// - cross products cover LL, RR, LR, RL of the selected polarisation pair
// - eight self multipliers per antenna square each sine or cosine component
// - compensating delay comes first; lag delays are sequenced internally
// - spectral mode uses sine products only, at positive and negative lags
// - sixteen lag multipliers serve the pair across one full band
// - samplers run at full rate; decimation happens before the multipliers
// - narrower bands replay stored samples to extend lags by N per pass
// - recirculation addresses up to 512 channels, operation limited to 256
// - single band mode correlates one chosen band
// - two band mode splits the multipliers between two chosen bands
// - four band mode gives each band a quarter of the multipliers
// - channels double per bandwidth halving up to the ceiling
// - delay steps are whole 10 ns clock periods
module ldm_correlator
  import ldm_pkg::*;
#(
  parameter int DELAY_MAX_P    = ldm_pkg::DELAY_MAX,
  parameter int INTEG_CYCLES_P = ldm_pkg::INTEG_CYCLES
) (
  // clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst,
  // sampler streams and walsh switching
  input  wire logic [ldm_pkg::STREAMS-1:0] i_x_samples,
  input  wire logic [ldm_pkg::STREAMS-1:0] i_y_samples,
  input  wire logic                        i_x_walsh,
  input  wire logic                        i_y_walsh,
  // apb slave
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [ldm_pkg::ADDR_W-1:0]  i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic      [31:0]                 o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  // monitor
  output logic                             o_handover
);
  import ldm_pkg::*;

  localparam int CNT_W = $clog2(2 * INTEG_CYCLES_P + 1);
  localparam int EP_W  = $clog2(INTEG_CYCLES_P + 1);

  function automatic logic [1:0] samp(input logic [STREAMS-1:0] d, input int ch, input int cosn);
    return d[ch * 4 + (cosn != 0 ? COS_OFS : SIN_OFS) +: 2];
  endfunction

  function automatic logic [PTR_W-1:0] ptr_back(input logic [PTR_W-1:0] a, input logic [PTR_W-1:0] n);
    logic [PTR_W:0] t;
    t = {1'b0, a} + (PTR_W + 1)'(MEM_DEPTH) - {1'b0, n};
    if (t >= (PTR_W + 1)'(MEM_DEPTH)) begin
      t = t - (PTR_W + 1)'(MEM_DEPTH);
    end
    return t[PTR_W-1:0];
  endfunction

  // ============================================================
  // registers
  logic [CTRL_W-1:0]   ctrl_q;
  logic [DELAY_W-1:0]  delay_q;
  logic                ready_q;
  logic [15:0]         epoch_q;
  logic [CNT_W-1:0]    mult_cnt_q;
  logic [CNT_W-1:0]    mult_hold_q;
  logic [EP_W-1:0]     ep_cnt_q;
  logic                epoch_end;

  wire              en       = ctrl_q[CTRL_EN_BIT];
  wire              spec     = ctrl_q[CTRL_SPEC_BIT];
  wire              pol_bd   = ctrl_q[CTRL_POL_BIT];
  wire [1:0]        band0    = ctrl_q[CTRL_BAND0_LSB +: 2];
  wire [1:0]        band1    = ctrl_q[CTRL_BAND1_LSB +: 2];
  wire [2:0]        dec_raw  = ctrl_q[CTRL_DEC_LSB +: 3];
  wire [2:0]        dec_log  = (dec_raw > 3'(MAX_DEC_LOG)) ? 3'(MAX_DEC_LOG) : dec_raw;
  ldm_band_mode_t   bmode;
  assign bmode = ldm_band_mode_t'(ctrl_q[CTRL_BMODE_LSB +: 2]);

  // ============================================================
  // walsh demodulation, then demultiplex into lanes
  wire [STREAMS-1:0] x_demod = i_x_samples ^ (i_x_walsh ? SIGN_MASK : '0);
  wire [STREAMS-1:0] y_demod = i_y_samples ^ (i_y_walsh ? SIGN_MASK : '0);

  logic [PH_W-1:0]                    ph_q;
  logic [STREAMS*DEMUX_LANES-1:0]     dmx_q;
  logic [STREAMS*DEMUX_LANES-1:0]     rdata_q;
  logic [PTR_W-1:0]                   wa_q;
  // one word holds sixteen consecutive samples of all streams, i.e. one bit of
  // each 6.25 mhz lane; the depth is two long segments plus one short one
  logic [STREAMS*DEMUX_LANES-1:0]     mem [MEM_DEPTH];
  logic [STREAMS-1:0]                 fine_q [DEMUX_LANES];
  logic [STREAMS-1:0]                 xd_q;
  logic [STREAMS-1:0]                 ylat_q [PATH_LAT];

  wire             word_done = (ph_q == PH_W'(DEMUX_LANES - 1));
  wire [PTR_W-1:0] wdel      = PTR_W'(delay_q[DELAY_W-1:PH_W]);
  wire [PH_W-1:0]  bdel      = delay_q[PH_W-1:0];
  wire [PTR_W-1:0] rd_addr   = ptr_back(wa_q, wdel + PTR_W'(1));
  wire [STREAMS*DEMUX_LANES-1:0] word_in = {x_demod, dmx_q[STREAMS*(DEMUX_LANES-1)-1:0]};
  wire [STREAMS-1:0] ser = rdata_q[ph_q * STREAMS +: STREAMS];
  wire [STREAMS-1:0] yd  = ylat_q[PATH_LAT-1];

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ph_q <= '0;
      wa_q <= '0;
    end else begin
      ph_q <= ph_q + PH_W'(1);
      if (word_done) begin
        wa_q <= (wa_q == PTR_W'(MEM_DEPTH - 1)) ? '0 : wa_q + PTR_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    dmx_q[ph_q * STREAMS +: STREAMS] <= x_demod;
    if (word_done) begin
      mem[wa_q] <= word_in;
      rdata_q   <= mem[rd_addr];
    end
  end

  // fine delay in whole clock periods; the word path gives the sixteens
  always_ff @(posedge i_clk_sys) begin
    fine_q[0] <= ser;
    for (int i = 1; i < DEMUX_LANES; i++) begin
      fine_q[i] <= fine_q[i-1];
    end
    xd_q <= fine_q[bdel];
    ylat_q[0] <= y_demod;
    for (int i = 1; i < PATH_LAT; i++) begin
      ylat_q[i] <= ylat_q[i-1];
    end
  end

  // ============================================================
  // decimation and recirculation passes
  logic [MAX_DEC_LOG-1:0] dcnt_q;
  logic [1:0]             xh_q [NUM_BANDS][LAG_DEPTH];
  logic [1:0]             yh_q [NUM_BANDS][LAG_DEPTH];

  wire [MAX_DEC_LOG-1:0] dmask    = MAX_DEC_LOG'((1 << dec_log) - 1);
  wire [MAX_DEC_LOG-1:0] pass     = dcnt_q & dmask;
  wire [2:0]             pl_log   = (dec_log > 3'(MAX_PASS_LOG)) ? 3'(MAX_PASS_LOG) : dec_log;
  wire                   pass_act = (pass < MAX_DEC_LOG'(1 << pl_log));
  wire                   dec_stb  = (pass == dmask);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      dcnt_q <= '0;
    end else begin
      dcnt_q <= dcnt_q + MAX_DEC_LOG'(1);
    end
  end

  // only one in 2^d full-rate samples enters the lag history
  always_ff @(posedge i_clk_sys) begin
    if (dec_stb) begin
      for (int b = 0; b < NUM_BANDS; b++) begin
        xh_q[b][0] <= samp(xd_q, b, 0);
        yh_q[b][0] <= samp(yd, b, 0);
        for (int l = 1; l < LAG_DEPTH; l++) begin
          xh_q[b][l] <= xh_q[b][l-1];
          yh_q[b][l] <= yh_q[b][l-1];
        end
      end
    end
  end

  // ============================================================
  // multipliers
  logic [1:0] cross_p [NUM_CROSS];
  logic [1:0] selfx_p [NUM_SELF];
  logic [1:0] selfy_p [NUM_SELF];
  logic [1:0] lagp_p  [NUM_LAGMUL];
  logic [1:0] lagn_p  [NUM_LAGMUL];
  logic [1:0] inc     [CHAN_MAX];
  int         nb_log;

  always_comb begin
    nb_log = (bmode == BAND_SINGLE) ? 0 : (bmode == BAND_TWO) ? 1 : 2;
  end

  function automatic logic [1:0] slot_band(input int slot, input int nbl,
                                           input logic [1:0] b0, input logic [1:0] b1);
    if (nbl == 0) begin
      return b0;
    end
    if (nbl == 1) begin
      return (slot != 0) ? b1 : b0;
    end
    return 2'(slot);
  endfunction

  always_comb begin
    int xch;
    int ych;
    logic [3:0] m;
    xch = 0;
    ych = 0;
    m   = '0;
    for (int k = 0; k < NUM_CROSS; k++) begin
      m   = CROSS_MAP[k*4 +: 4];
      xch = m[3] ? (pol_bd ? 1 : 0) : (pol_bd ? 3 : 2);
      ych = m[1] ? (pol_bd ? 1 : 0) : (pol_bd ? 3 : 2);
      cross_p[k] = ldm_mul3(samp(xd_q, xch, int'(m[2])), samp(yd, ych, int'(m[0])));
    end
    for (int j = 0; j < NUM_SELF; j++) begin
      selfx_p[j] = ldm_mul3(samp(xd_q, j / 2, j % 2), samp(xd_q, j / 2, j % 2));
      selfy_p[j] = ldm_mul3(samp(yd, j / 2, j % 2), samp(yd, j / 2, j % 2));
    end
  end

  // sixteen lag multipliers; in pass p multiplier k sees lag p*lanes + lane, so a
  // replay of the stored samples adds N sample intervals per pass
  always_comb begin
    int lanes_log;
    int lane;
    int slot;
    int lag;
    logic [1:0] bd;
    lanes_log = MAX_PASS_LOG - nb_log;
    lane = 0;
    slot = 0;
    lag  = 0;
    bd   = '0;
    for (int k = 0; k < NUM_LAGMUL; k++) begin
      lane = k & ((1 << lanes_log) - 1);
      slot = k >> lanes_log;
      lag  = (int'(pass) << lanes_log) | lane;
      if (lag >= LAG_DEPTH) begin
        lag = LAG_DEPTH - 1;
      end
      bd = slot_band(slot, nb_log, band0, band1);
      lagp_p[k] = ldm_mul3(xh_q[bd][lag], yh_q[bd][0]);
      lagn_p[k] = ldm_mul3(yh_q[bd][lag], xh_q[bd][0]);
    end
  end

  // route each product to its channel counter; no multiply means no count
  always_comb begin
    int clog;
    int j;
    int slot;
    int lag;
    int pidx;
    int k;
    clog = MAX_PASS_LOG + int'(pl_log) - nb_log;
    j = 0;
    slot = 0;
    lag = 0;
    pidx = 0;
    k = 0;
    for (int i = 0; i < CHAN_MAX; i++) begin
      inc[i] = 2'h0;
      if (en && !spec) begin
        if (i < NUM_CROSS) begin
          inc[i] = cross_p[i];
        end else if (i < NUM_CROSS + NUM_SELF) begin
          inc[i] = selfx_p[i - NUM_CROSS];
        end else if (i < NUM_CROSS + 2 * NUM_SELF) begin
          inc[i] = selfy_p[i - NUM_CROSS - NUM_SELF];
        end
      end else if (en && spec && pass_act) begin
        j    = i % CHAN_LIMIT;
        slot = j >> clog;
        lag  = j & ((1 << clog) - 1);
        pidx = lag >> (MAX_PASS_LOG - nb_log);
        k    = (slot << (MAX_PASS_LOG - nb_log)) | (lag & ((1 << (MAX_PASS_LOG - nb_log)) - 1));
        if (slot < (1 << nb_log) && pidx == int'(pass)) begin
          inc[i] = (i >= CHAN_LIMIT) ? lagn_p[k] : lagp_p[k];
        end
      end
    end
  end

  // ============================================================
  // integration and handover
  logic [CNT_W-1:0] cnt_q  [CHAN_MAX];
  logic [CNT_W-1:0] hold_q [CHAN_MAX];

  assign epoch_end = (ep_cnt_q == EP_W'(INTEG_CYCLES_P - 1));
  wire mult_evt = en && (!spec || (pass == '0));

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ep_cnt_q <= '0;
    end else begin
      ep_cnt_q <= epoch_end ? '0 : ep_cnt_q + EP_W'(1);
    end
  end

  // the product of the handover cycle opens the next period
  always_ff @(posedge i_clk_sys) begin
    for (int i = 0; i < CHAN_MAX; i++) begin
      if (i_rst) begin
        cnt_q[i]  <= '0;
        hold_q[i] <= '0;
      end else if (epoch_end) begin
        hold_q[i] <= cnt_q[i];
        cnt_q[i]  <= CNT_W'(inc[i]);
      end else begin
        cnt_q[i]  <= cnt_q[i] + CNT_W'(inc[i]);
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mult_cnt_q  <= '0;
      mult_hold_q <= '0;
      epoch_q     <= '0;
      o_handover  <= 1'b0;
    end else begin
      o_handover <= epoch_end;
      if (epoch_end) begin
        mult_hold_q <= mult_cnt_q;
        mult_cnt_q  <= CNT_W'(mult_evt);
        epoch_q     <= epoch_q + 16'h0001;
      end else begin
        mult_cnt_q  <= mult_cnt_q + CNT_W'(mult_evt);
      end
    end
  end

  // ============================================================
  // apb slave, one wait state
  wire apb_acc  = i_psel && i_penable && !o_pready;
  wire in_hold  = i_paddr[HOLD_SEL_BIT] && (i_paddr[1:0] == 2'h0);
  wire hit_ctrl = (i_paddr == OFS_CTRL);
  wire hit_dly  = (i_paddr == OFS_DELAY);
  wire hit_stat = (i_paddr == OFS_STATUS);
  wire hit_ep   = (i_paddr == OFS_EPOCH);
  wire hit_mc   = (i_paddr == OFS_MULTS);
  wire hit_rd   = in_hold || hit_ctrl || hit_dly || hit_stat || hit_ep || hit_mc;
  wire hit_wr   = hit_ctrl || hit_dly || hit_stat;
  wire hit      = i_pwrite ? hit_wr : hit_rd;
  // writes land only at the edge where the master samples ready high
  wire wr_en    = i_psel && i_penable && o_pready && i_pwrite && hit;
  wire [SEL_W-1:0] hsel = i_paddr[SEL_W+1:2];
  wire [DELAY_W-1:0] dly_in = (i_pwdata[DELAY_W-1:0] > DELAY_W'(DELAY_MAX_P))
                              ? DELAY_W'(DELAY_MAX_P) : i_pwdata[DELAY_W-1:0];
  wire [31:0] rd_word = in_hold  ? 32'(hold_q[hsel]) :
                        hit_ctrl ? 32'(ctrl_q) :
                        hit_dly  ? 32'(delay_q) :
                        hit_stat ? {29'h0, dec_stb, spec, ready_q} :
                        hit_ep   ? {16'h0000, epoch_q} :
                        hit_mc   ? 32'(mult_hold_q) : 32'h0000_0000;
  wire clr_ready = wr_en && hit_stat && i_pwdata[STAT_READY_BIT];

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= apb_acc;
      o_pslverr <= apb_acc && !hit;
      o_prdata  <= (apb_acc && !i_pwrite && hit) ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_q  <= CTRL_RESET;
      delay_q <= DELAY_RESET;
      ready_q <= 1'b0;
    end else begin
      if (wr_en && hit_ctrl) begin
        ctrl_q <= i_pwdata[CTRL_W-1:0];
      end
      if (wr_en && hit_dly) begin
        delay_q <= dly_in;
      end
      // a handover in the clearing cycle keeps the flag set
      ready_q <= epoch_end || (ready_q && !clr_ready);
    end
  end

endmodule

`default_nettype wire

// File: ldm_correlator_properties.sv
// concurrent checks on the correlator's apb and handover ports
`timescale 1ns/1ps
`default_nettype none
module ldm_correlator_properties
  import ldm_pkg::*;
#(
  parameter int INTEG_CYCLES_P = 200
) (
  // clock and reset
  input wire logic                       i_clk_sys,
  input wire logic                       i_rst,
  // apb
  input wire logic                       i_psel,
  input wire logic                       i_penable,
  input wire logic                       i_pwrite,
  input wire logic [ldm_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0]                o_prdata,
  input wire logic                       o_pready,
  input wire logic                       o_pslverr,
  // monitor
  input wire logic                       o_handover
);
  // ============================================================
  // helper: cycles since the previous handover
  logic [31:0] gap_q;
  logic        seen_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= o_handover ? 32'h1 : gap_q + 32'h1;
      seen_q <= seen_q | o_handover;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ============================================================
  // assertions
  pready_lat_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("ready did not follow the first access cycle");
  pready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready stood longer than one cycle");
  prdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("read data outside the ready cycle");
  err_has_ready_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error without ready or with data");
  ro_write_err_a: assert property (i_psel && i_penable && i_pwrite && !o_pready
    && i_paddr == OFS_EPOCH |=> o_pslverr)
    else $error("write to read-only place accepted");
  handover_pulse_a: assert property (o_handover |=> !o_handover)
    else $error("handover longer than one cycle");
  handover_period_a: assert property (o_handover && seen_q |-> gap_q == 32'(INTEG_CYCLES_P))
    else $error("handover spacing wrong");
  reset_quiet_a: assert property ($fell(i_rst) |-> !o_pready && !o_handover && !o_pslverr)
    else $error("outputs active right after reset");
endmodule
`default_nettype wire

// File: ldm_pkg.sv
// shared constants, types and helpers for the lag correlator delay multiplier
package ldm_pkg;

  // ============================================================
  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int INTEG_PERIOD_US = 52000;
  localparam int INTEG_CYCLES    = INTEG_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int DELAY_SPAN_NS   = 164000;
  localparam int DELAY_MAX       = DELAY_SPAN_NS / CLK_PERIOD_NS;

  // ============================================================
  // structure
  localparam int STREAMS     = 16;   // 4 if channels x (sine sign, sine mag, cos sign, cos mag)
  localparam int DEMUX_LANES = 16;
  localparam int PH_W        = 4;
  localparam int SEG_SHORT   = 256;
  localparam int SEG_LONG    = 512;
  localparam int MEM_DEPTH   = 2 * SEG_LONG + SEG_SHORT;
  localparam int PTR_W       = 11;
  localparam int DELAY_W     = 15;
  localparam int PATH_LAT    = 34;
  localparam int NUM_BANDS   = 4;
  localparam int NUM_CROSS   = 16;
  localparam int NUM_SELF    = 8;
  localparam int NUM_LAGMUL  = 16;
  localparam int CHAN_MAX    = 512;
  localparam int CHAN_LIMIT  = 256;
  localparam int RECIRC_MAX  = 32;
  localparam int MAX_PASS_LOG = 4;   // 16 passes x 16 multipliers = channel limit
  localparam int MAX_DEC_LOG  = 5;
  localparam int LAG_DEPTH    = CHAN_LIMIT;
  localparam int SEL_W        = 9;

  // ============================================================
  // sample nibble layout
  localparam int SIN_OFS  = 0;
  localparam int COS_OFS  = 2;
  localparam logic [STREAMS-1:0] SIGN_MASK = 16'h5555;

  // product table: nibble {x is L, x is cos, y is L, y is cos}
  localparam logic [63:0] CROSS_MAP = 64'hC963_EB41_D872_FA50;

  // ============================================================
  // apb map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_DELAY  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_EPOCH  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_MULTS  = 12'h010;
  localparam int HOLD_SEL_BIT = 11;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_SPEC_BIT  = 1;
  localparam int CTRL_BMODE_LSB = 2;
  localparam int CTRL_DEC_LSB   = 4;
  localparam int CTRL_BAND0_LSB = 7;
  localparam int CTRL_BAND1_LSB = 9;
  localparam int CTRL_POL_BIT   = 11;
  localparam int CTRL_W         = 12;
  localparam logic [CTRL_W-1:0]  CTRL_RESET  = 12'h000;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 15'h0000;
  localparam int STAT_READY_BIT = 0;

  typedef enum logic [1:0] {
    BAND_SINGLE,
    BAND_TWO,
    BAND_FOUR,
    BAND_FOUR_ALT
  } ldm_band_mode_t;

  // three-level product as counter increment: -1 -> 0, 0 -> 1, +1 -> 2
  // sample is {mag, sign}
  function automatic logic [1:0] ldm_mul3(input logic [1:0] a, input logic [1:0] b);
    if (a[1] && b[1]) begin
      return (a[0] == b[0]) ? 2'h2 : 2'h0;
    end
    return 2'h1;
  endfunction

endpackage

// File: ldm_sampler_model.sv
// sampler pair model: quantised sign and magnitude codes for two antennas
`timescale 1ns/1ps
`default_nettype none
module ldm_sampler_model
  import ldm_pkg::*;
(
  // clock and command
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_load,
  input  wire logic [ldm_pkg::STREAMS-1:0] i_x_code,
  input  wire logic [ldm_pkg::STREAMS-1:0] i_y_code,
  // streams
  output logic      [ldm_pkg::STREAMS-1:0] o_x_samples,
  output logic      [ldm_pkg::STREAMS-1:0] o_y_samples
);
  logic [STREAMS-1:0] x_q = '0;
  logic [STREAMS-1:0] y_q = '0;
  // codes only move on command, so whole integration periods see one pair
  always @(posedge i_clk_sys) begin
    if (i_load) begin
      x_q <= i_x_code;
      y_q <= i_y_code;
    end
  end
  assign o_x_samples = x_q;
  assign o_y_samples = y_q;
endmodule
`default_nettype wire
